// ===== rtl/channel_initial_state_gate.sv
// Per-channel initial-state gate of the sideband command handler
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "gate_regs.svh"
module channel_initial_state_gate
   import gate_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter int UC_N = 4,
   parameter int NOTICE_W = 8,
   parameter int CNT_W = 16,
   parameter bit HW_ARB_CAP = 1'b1
) (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   input wire logic [2:0] PKG_ID_I,
   input wire logic PKG_READY_I,
   input wire logic LINK_UP_I,
   input wire logic [NUM_CH-1:0] FAULT_I,
   input wire logic [NUM_CH-1:0] PT_RX_I,
   input wire logic CMD_VALID_I,
   input wire logic [7:0] CMD_CHID_I,
   input wire logic [7:0] CMD_OP_I,
   input wire logic CMD_VENDOR_I,
   input wire logic [7:0] CMD_TAG_I,
   input wire logic [7:0] CMD_DATA_I,
   output logic RSP_VALID_O,
   output logic [15:0] RSP_CODE_O,
   output logic [15:0] RSP_REASON_O,
   output logic [CNT_W-1:0] RSP_DATA_O,
   output logic [NUM_CH-1:0] CH_INIT_O,
   output logic [NUM_CH-1:0] CH_ENABLED_O,
   output logic [NUM_CH-1:0] NET_TX_O,
   output logic [NUM_CH-1:0] UNREQ_TX_OK_O,
   output logic [NUM_CH-1:0] NOTICE_TX_OK_O,
   output logic PKG_SELECTED_O,
   output logic HW_ARB_O,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O
);

   function automatic logic is_pkg(input logic [7:0] id);
      return id[`CHID_INT_W-1:0] == `CHID_PKG_ALL;
   endfunction

   function automatic logic is_cmd(input logic [7:0] op,
                                   input cmd_e c);
      return op == c;
   endfunction

   logic [NUM_CH-1:0] init_q, en_q, ntx_q, tagv_q, vlan_q, mcbc_q;
   logic [NOTICE_W-1:0] notice_q [NUM_CH];
   logic [UC_N-1:0] uc_q [NUM_CH];
   logic [CNT_W-1:0] cnt_q [NUM_CH];
   logic [7:0] tag_q [NUM_CH];
   logic sel_q, arb_q, arb_cap_q, ack_q;
   logic [31:0] dat_q;
   logic rsp_valid_q;
   logic [15:0] code_q, reason_q;
   logic [CNT_W-1:0] rdata_q;

   logic [NUM_CH-1:0] hit, refuse, dup, exec, enter, clr_ok;
   logic [NUM_CH-1:0] cfg_lost;
   logic pkg_match, pkg_hit, ch_hit, std, known;
   logic wb_req, wb_wr;
   logic [`CHID_INT_W-1:0] int_id;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);

   // Channel address is package id plus internal number
   assign int_id = CMD_CHID_I[`CHID_INT_W-1:0];
   assign pkg_match = CMD_CHID_I[7:`CHID_PKG_LSB] == PKG_ID_I;
   assign pkg_hit = CMD_VALID_I & pkg_match & is_pkg(CMD_CHID_I);
   assign ch_hit = CMD_VALID_I & pkg_match & !is_pkg(CMD_CHID_I);
   assign std = !CMD_VENDOR_I;
   assign known = CMD_OP_I <= CMD_GET_STATS;

   assign wb_req = WB_CYC_I & WB_STB_I;
   assign wb_wr = wb_req & WB_WE_I & ack_q;

   // Software reports a configuration loss per channel
   always_comb begin
      cfg_lost = '0;
      if (wb_wr && WB_ADR_I == `ADR_CTRL && WB_SEL_I[0]) begin
         cfg_lost = WB_DAT_I[NUM_CH-1:0];
      end
   end

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      assign hit[c] = ch_hit & (int_id == `CHID_INT_W'(c));
      // In the initial state, standard commands other than clear are refused
      assign refuse[c] = hit[c] & init_q[c] & std
         & !is_cmd(CMD_OP_I, CMD_CLEAR_INIT);
      // A repeated tag replays the answer, no second action
      assign dup[c] = hit[c] & !init_q[c] & tagv_q[c]
         & (tag_q[c] == CMD_TAG_I);
      assign exec[c] = hit[c] & !refuse[c] & !dup[c] & std;
      assign clr_ok[c] = exec[c] & is_cmd(CMD_OP_I, CMD_CLEAR_INIT);
      assign enter[c] = FAULT_I[c] | cfg_lost[c]
         | (exec[c] & is_cmd(CMD_OP_I, CMD_RESET_CH));

      // Entry wins over a clear in the same cycle
      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            init_q[c] <= 1'b1;
         end else if (enter[c]) begin
            init_q[c] <= 1'b1;
         end else if (clr_ok[c]) begin
            init_q[c] <= 1'b0;
         end
      end

      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            en_q[c] <= 1'b0;
            ntx_q[c] <= 1'b0;
         end else if (enter[c]) begin
            en_q[c] <= 1'b0;
            ntx_q[c] <= 1'b0;
         end else if (exec[c]) begin
            if (is_cmd(CMD_OP_I, CMD_ENABLE_CH)) begin
               en_q[c] <= 1'b1;
            end
            if (is_cmd(CMD_OP_I, CMD_DISABLE_CH)) begin
               en_q[c] <= 1'b0;
            end
            if (is_cmd(CMD_OP_I, CMD_NET_TX_ON)) begin
               ntx_q[c] <= 1'b1;
            end
            if (is_cmd(CMD_OP_I, CMD_NET_TX_OFF)) begin
               ntx_q[c] <= 1'b0;
            end
         end
      end

      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            uc_q[c] <= '0;
            vlan_q[c] <= 1'b0;
            mcbc_q[c] <= 1'b0;
            notice_q[c] <= '0;
         end else if (enter[c]) begin
            uc_q[c] <= '0;
            vlan_q[c] <= 1'b0;
            mcbc_q[c] <= 1'b0;
            notice_q[c] <= '0;
         end else if (exec[c]) begin
            if (is_cmd(CMD_OP_I, CMD_SET_UCAST)) begin
               uc_q[c] <= CMD_DATA_I[UC_N-1:0];
            end
            if (is_cmd(CMD_OP_I, CMD_SET_VLAN)) begin
               vlan_q[c] <= CMD_DATA_I[0];
            end
            if (is_cmd(CMD_OP_I, CMD_SET_MCBC)) begin
               mcbc_q[c] <= CMD_DATA_I[0];
            end
            if (is_cmd(CMD_OP_I, CMD_SET_NOTICE)) begin
               notice_q[c] <= CMD_DATA_I[NOTICE_W-1:0];
            end
         end
      end

      // Counters saturate rather than wrap, so a stale read is obvious
      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            cnt_q[c] <= '0;
         end else if (enter[c]) begin
            cnt_q[c] <= '0;
         end else if (PT_RX_I[c] && cnt_q[c] != '1) begin
            cnt_q[c] <= cnt_q[c] + CNT_W'(1);
         end
      end

      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
         if (!RESETN_I) begin
            tagv_q[c] <= 1'b0;
            tag_q[c] <= '0;
         end else if (enter[c]) begin
            tagv_q[c] <= 1'b0;
         end else if (exec[c]) begin
            tagv_q[c] <= 1'b1;
            tag_q[c] <= CMD_TAG_I;
         end
      end

      // Only command answers leave a disabled channel
      assign UNREQ_TX_OK_O[c] = en_q[c] & sel_q;
      assign NOTICE_TX_OK_O[c] = en_q[c] & sel_q & (|notice_q[c]);

      property p_enter_clean;
         enter[c] |=> init_q[c] && !en_q[c] && !ntx_q[c]
            && cnt_q[c] == '0 && uc_q[c] == '0 && !vlan_q[c]
            && notice_q[c] == '0 && !tagv_q[c] && !mcbc_q[c];
      endproperty
      a_enter_clean: assert property (p_enter_clean)
         else $error("channel not defaulted on initial-state entry");

      property p_init_hold;
         init_q[c] && !clr_ok[c] |=> init_q[c];
      endproperty
      a_init_hold: assert property (p_init_hold)
         else $error("initial state left without clear command");

      property p_clear_leaves;
         clr_ok[c] && !enter[c] |=> !init_q[c];
      endproperty
      a_clear_leaves: assert property (p_clear_leaves)
         else $error("clear command did not leave initial state");

      property p_unreq;
         !en_q[c] |-> !UNREQ_TX_OK_O[c] && !NOTICE_TX_OK_O[c];
      endproperty
      a_unreq: assert property (p_unreq)
         else $error("disabled channel may send unrequested packet");

      property p_init_answers;
         hit[c] |=> RSP_VALID_O;
      endproperty
      a_init_answers: assert property (p_init_answers)
         else $error("channel command left without answer");
   end

   // Package selection and arbitration; arbitration survives entry
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sel_q <= 1'b0;
         arb_q <= 1'b1;
      end else if (pkg_hit && PKG_READY_I && std) begin
         if (is_cmd(CMD_OP_I, CMD_SELECT_PKG)) begin
            sel_q <= 1'b1;
         end
         if (is_cmd(CMD_OP_I, CMD_DESELECT_PKG)) begin
            sel_q <= 1'b0;
         end
         if (is_cmd(CMD_OP_I, CMD_SET_HW_ARB)) begin
            arb_q <= CMD_DATA_I[0];
         end
      end
   end

   // Answer builder; one answer per accepted command
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rsp_valid_q <= 1'b0;
         code_q <= `RSP_OK;
         reason_q <= `RSN_NONE;
         rdata_q <= '0;
      end else begin
         rsp_valid_q <= (pkg_hit & PKG_READY_I) | (|hit);
         code_q <= `RSP_OK;
         reason_q <= `RSN_NONE;
         rdata_q <= '0;
         if (|refuse) begin
            code_q <= `RSP_FAIL;
            reason_q <= `RSN_INIT_REQ;
         end else if ((pkg_hit | ch_hit) && std && !known) begin
            code_q <= `RSP_FAIL;
            reason_q <= `RSN_UNSUP;
         end else begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (hit[i] && is_cmd(CMD_OP_I, CMD_GET_STATS)) begin
                  rdata_q <= cnt_q[i];
               end
            end
         end
      end
   end

   // Wishbone slave: ack one cycle after request, write at ack edge
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= wb_req & !ack_q;
         if (wb_req && !ack_q) begin
            dat_q <= '0;
            if (WB_ADR_I == `ADR_CTRL) begin
               dat_q[`CTRL_ARB_BIT] <= arb_cap_q;
            end else if (WB_ADR_I == `ADR_STATUS) begin
               dat_q[NUM_CH-1:0] <= init_q;
               dat_q[`ST_EN_LSB +: NUM_CH] <= en_q;
               dat_q[`ST_NTX_LSB +: NUM_CH] <= ntx_q;
               dat_q[`ST_SEL_BIT] <= sel_q;
               dat_q[`ST_ARB_BIT] <= HW_ARB_O;
               dat_q[`ST_LINK_BIT] <= LINK_UP_I;
            end
            for (int i = 0; i < NUM_CH; i++) begin
               if (WB_ADR_I == {`ADR_CNT, 2'(i), 2'b00}) begin
                  dat_q[CNT_W-1:0] <= cnt_q[i];
               end
               if (WB_ADR_I == {`ADR_FILT, 2'(i), 2'b00}) begin
                  dat_q[NOTICE_W-1:0] <= notice_q[i];
                  dat_q[`FI_UC_LSB +: UC_N] <= uc_q[i];
                  dat_q[`FI_VLAN_BIT] <= vlan_q[i];
                  dat_q[`FI_MCBC_BIT] <= mcbc_q[i];
               end
            end
         end
      end
   end

   // Arbitration capability is a software strap
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         arb_cap_q <= HW_ARB_CAP;
      end else if (wb_wr && WB_ADR_I == `ADR_CTRL && WB_SEL_I[1]) begin
         arb_cap_q <= WB_DAT_I[`CTRL_ARB_BIT];
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
   assign RSP_VALID_O = rsp_valid_q;
   assign RSP_CODE_O = code_q;
   assign RSP_REASON_O = reason_q;
   assign RSP_DATA_O = rdata_q;
   assign CH_INIT_O = init_q;
   assign CH_ENABLED_O = en_q;
   assign NET_TX_O = ntx_q;
   assign PKG_SELECTED_O = sel_q;
   assign HW_ARB_O = arb_q & arb_cap_q;

   property p_refuse;
      |refuse |=> RSP_VALID_O && RSP_CODE_O == `RSP_FAIL
         && RSP_REASON_O == `RSN_INIT_REQ;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("initial-state refusal answer wrong");

   property p_pkg_served;
      pkg_hit && PKG_READY_I && std && known |=> RSP_VALID_O
         && RSP_CODE_O == `RSP_OK;
   endproperty
   a_pkg_served: assert property (p_pkg_served)
      else $error("package command not served normally");

   property p_arb_kept;
      !(pkg_hit && is_cmd(CMD_OP_I, CMD_SET_HW_ARB))
         && !(wb_wr && WB_ADR_I == `ADR_CTRL) |=> $stable(HW_ARB_O);
   endproperty
   a_arb_kept: assert property (p_arb_kept)
      else $error("arbitration setting changed by itself");

   sequence s_wb_req;
      wb_req && !ack_q;
   endsequence
   sequence s_wb_ans;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   property p_wb;
      s_wb_req |=> s_wb_ans;
   endproperty
   a_wb: assert property (p_wb)
      else $error("bus acknowledge timing wrong");

endmodule

// ===== rtl/gate_regs.svh
// Constants of the channel initial-state command gate
`ifndef GATE_REGS_SVH
`define GATE_REGS_SVH
`define CHID_INT_W 5
`define CHID_PKG_LSB 5
`define CHID_PKG_ALL 5'h1f
`define RSP_OK 16'h0000
`define RSP_FAIL 16'h0001
`define RSN_NONE 16'h0000
`define RSN_INIT_REQ 16'h0001
`define RSN_UNSUP 16'h0002
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_CNT 4'h1
`define ADR_FILT 4'h2
`define CTRL_ARB_BIT 8
`define ST_EN_LSB 8
`define ST_NTX_LSB 16
`define ST_SEL_BIT 24
`define ST_ARB_BIT 25
`define ST_LINK_BIT 26
`define FI_UC_LSB 8
`define FI_VLAN_BIT 12
`define FI_MCBC_BIT 13
`endif

// ===== rtl/gate_pkg.sv
// Types shared by the channel initial-state command gate
package gate_pkg;
   typedef enum logic [7:0] {
      CMD_CLEAR_INIT = 8'h00,
      CMD_SELECT_PKG = 8'h01,
      CMD_DESELECT_PKG = 8'h02,
      CMD_ENABLE_CH = 8'h03,
      CMD_DISABLE_CH = 8'h04,
      CMD_RESET_CH = 8'h05,
      CMD_NET_TX_ON = 8'h06,
      CMD_NET_TX_OFF = 8'h07,
      CMD_SET_NOTICE = 8'h08,
      CMD_SET_UCAST = 8'h09,
      CMD_SET_VLAN = 8'h0a,
      CMD_SET_MCBC = 8'h0b,
      CMD_SET_HW_ARB = 8'h0c,
      CMD_GET_STATS = 8'h0d
   } cmd_e;
endpackage

// ===== tb/mc_model.sv
// Management controller model issuing sideband commands
`timescale 1ns/10ps
module mgmt_ctrl_model #(
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_chid_o,
   output logic [7:0] cmd_op_o,
   output logic cmd_vendor_o,
   output logic [7:0] cmd_tag_o,
   output logic [7:0] cmd_data_o,
   input wire logic rsp_valid_i,
   input wire logic [15:0] rsp_code_i,
   input wire logic [15:0] rsp_reason_i,
   input wire logic [CNT_W-1:0] rsp_data_i
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_chid_o = 8'h00;
      cmd_op_o = 8'h00;
      cmd_vendor_o = 1'b0;
      cmd_tag_o = 8'h00;
      cmd_data_o = 8'h00;
   end
   // Sets what it needs, never reads back undefined defaults
   task automatic cmd(input logic [7:0] chid, input logic [7:0] op,
      input logic vend, input logic [7:0] tag, input logic [7:0] data,
      output logic got, output logic [15:0] code,
      output logic [15:0] reason, output logic [CNT_W-1:0] rdata);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_chid_o <= chid;
      cmd_op_o <= op;
      cmd_vendor_o <= vend;
      cmd_tag_o <= tag;
      cmd_data_o <= data;
      @(posedge clk_i);
      // Released fields flip so stale values never look valid
      cmd_valid_o <= 1'b0;
      cmd_chid_o <= ~chid;
      cmd_op_o <= ~op;
      cmd_vendor_o <= ~vend;
      cmd_tag_o <= ~tag;
      cmd_data_o <= ~data;
      #1;
      got = rsp_valid_i;
      code = rsp_code_i;
      reason = rsp_reason_i;
      rdata = rsp_data_i;
   endtask
endmodule

// ===== tb/tb_channel_initial_state_gate.sv
// Testbench of the channel initial-state command gate
`timescale 1ns/10ps
`include "gate_regs.svh"
module tb_channel_initial_state_gate import gate_pkg::*;;
   logic clk, rstn, rdy, link, cv, cvend, rv, sel_o, arb, cyc, stb, we, ack;
   logic [1:0] fault, ptrx, init, en, ntx, unreq, ntc;
   logic [7:0] chid, op, tag, data, adr;
   logic [15:0] rc, rr, rd, code, reason, rdata;
   logic [3:0] sel;
   logic [31:0] wdat, wbq, rw;
   logic got;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   channel_initial_state_gate #(.NUM_CH(2), .CNT_W(16))
      u_channel_initial_state_gate (.CORE_CLK_I(clk), .RESETN_I(rstn),
      .PKG_ID_I(3'h2), .PKG_READY_I(rdy), .LINK_UP_I(link), .FAULT_I(fault),
      .PT_RX_I(ptrx), .CMD_VALID_I(cv), .CMD_CHID_I(chid), .CMD_OP_I(op),
      .CMD_VENDOR_I(cvend), .CMD_TAG_I(tag), .CMD_DATA_I(data),
      .RSP_VALID_O(rv), .RSP_CODE_O(rc), .RSP_REASON_O(rr),
      .RSP_DATA_O(rd), .CH_INIT_O(init), .CH_ENABLED_O(en), .NET_TX_O(ntx),
      .UNREQ_TX_OK_O(unreq), .NOTICE_TX_OK_O(ntc), .PKG_SELECTED_O(sel_o),
      .HW_ARB_O(arb), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(wbq),
      .WB_ACK_O(ack));
   mgmt_ctrl_model #(.CNT_W(16)) u_mgmt_ctrl_model (.clk_i(clk),
      .cmd_valid_o(cv), .cmd_chid_o(chid), .cmd_op_o(op),
      .cmd_vendor_o(cvend),
      .cmd_tag_o(tag), .cmd_data_o(data), .rsp_valid_i(rv),
      .rsp_code_i(rc), .rsp_reason_i(rr), .rsp_data_i(rd));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         $display("MISMATCH %0t timeout", $time);
         end_sim();
      end
   end
   task automatic chk_bits(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_rsp(input logic eg, input logic [15:0] ec,
      input logic [15:0] er);
      num_checks++;
      if (got !== eg || (eg && (code !== ec || reason !== er))) begin
         num_errors++;
         $display("MISMATCH %0t answer %b %h %h", $time, got, code, reason);
      end
   endtask
   task automatic send(input logic [7:0] c, input logic [7:0] o,
      input logic v, input logic [7:0] t, input logic [7:0] d);
      u_mgmt_ctrl_model.cmd(c, o, v, t, d, got, code, reason, rdata);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rw = wbq;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   logic [7:0] cops [7] = '{CMD_ENABLE_CH, CMD_NET_TX_ON, CMD_SET_NOTICE,
      CMD_SET_UCAST, CMD_SET_VLAN, CMD_SET_MCBC, CMD_SET_HW_ARB};
   logic [7:0] cdat [7] = '{8'h00, 8'h00, 8'hff, 8'h0f, 8'h01, 8'h01, 8'h00};
   initial begin
      rstn = 1'b0; rdy = 1'b1; link = 1'b0; fault = 2'b00; ptrx = 2'b00;
      cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
      wdat = 32'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      link <= 1'b1;
      #1;
      chk_bits(init, 2'b11);
      chk_bits(en, 2'b00);
      chk_bits(arb, 1'b1);
      send(8'h5f, CMD_SELECT_PKG, 1'b0, 8'h01, 8'h00);
      chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      chk_bits(sel_o, 1'b1);
      for (int i = 1; i < 14; i++) begin
         send(8'h40, 8'(i), 1'b0, 8'(8'h10 + i), 8'h00);
         chk_rsp(1'b1, `RSP_FAIL, `RSN_INIT_REQ);
      end
      chk_bits(en, 2'b00);
      send(8'h40, CMD_ENABLE_CH, 1'b1, 8'h1e, 8'h00);
      chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      // Recovery after the refusal
      send(8'h40, CMD_CLEAR_INIT, 1'b0, 8'h20, 8'h00);
      chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      chk_bits(init, 2'b10);
      for (int i = 0; i < 7; i++) begin
         send(8'h40, cops[i], 1'b0, 8'(8'h21 + i), cdat[i]);
         chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      end
      send(8'h5f, CMD_SET_HW_ARB, 1'b0, 8'h28, 8'h00);
      chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      chk_bits({en, ntx, unreq, ntc, 1'b0, arb}, 11'h154);
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      chk_bits(rw, 32'h3fff);
      repeat (3) begin
         @(posedge clk) ptrx <= 2'b01;
         @(posedge clk) ptrx <= 2'b00;
      end
      send(8'h40, CMD_GET_STATS, 1'b0, 8'h30, 8'h00);
      chk_bits(rdata, 16'h3);
      send(8'h40, CMD_RESET_CH, 1'b0, 8'h40, 8'h00);
      chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      chk_bits({init, en, ntx, unreq, ntc, arb}, 11'h600);
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      chk_bits(rw, 32'h0);
      wb(1'b0, `ADR_STATUS, 4'hf, 32'h0);
      chk_bits(rw[`ST_LINK_BIT], 1'b1);
      send(8'h40, CMD_CLEAR_INIT, 1'b0, 8'h40, 8'h00);
      chk_bits(init, 2'b10);
      send(8'h40, CMD_GET_STATS, 1'b0, 8'h41, 8'h00);
      chk_bits(rdata, 16'h0);
      send(8'h41, CMD_CLEAR_INIT, 1'b0, 8'h50, 8'h00);
      chk_bits(init, 2'b00);
      @(posedge clk) fault <= 2'b10;
      @(posedge clk) fault <= 2'b00;
      #1;
      chk_bits(init, 2'b10);
      wb(1'b1, `ADR_CTRL, 4'h1, 32'h1);
      @(posedge clk);
      #1;
      chk_bits({init, arb}, 3'b110);
      @(posedge clk) rdy <= 1'b0;
      send(8'h5f, CMD_DESELECT_PKG, 1'b0, 8'h60, 8'h00);
      chk_rsp(1'b0, `RSP_OK, `RSN_NONE);
      @(posedge clk) rdy <= 1'b1;
      send(8'h5f, CMD_DESELECT_PKG, 1'b0, 8'h61, 8'h00);
      chk_rsp(1'b1, `RSP_OK, `RSN_NONE);
      chk_bits(sel_o, 1'b0);
      send(8'h60, CMD_CLEAR_INIT, 1'b0, 8'h62, 8'h00);
      chk_rsp(1'b0, `RSP_OK, `RSN_NONE);
      wb(1'b0, 8'h40, 4'hf, 32'h0);
      chk_bits(rw, 32'h0);
      end_sim();
   end
endmodule
